// ==== rtl/mq_cfg_regs.svh ====
/*
  Constants of the multi-queue configuration block: register count,
  register addresses, reset values, field positions and timing counts.
  Assumes it is included by bare name from rtl/ and holds definitions only.
*/
`ifndef MQ_CFG_REGS_SVH
`define MQ_CFG_REGS_SVH

// Register file shape
`define CFG_NUM_REGS      10
`define CFG_WIDTH         8
`define CFG_ADDR_FIRST    8'h01
`define CFG_ADDR_LAST     8'h0A
`define CFG_QCOUNT_ADDR   8'h03
`define CFG_QCOUNT_IDX    4'h2
`define CFG_FASTCLK_ADDR  8'h0A

// Queue-count field position inside register 0x3
`define CFG_QCOUNT_MSB    2
`define CFG_QCOUNT_LSB    0

// Reset values, first register to tenth
`define CFG_RST_R1        8'h00
`define CFG_RST_R2        8'h00
`define CFG_RST_R3        8'h07
`define CFG_RST_R4        8'h7F
`define CFG_RST_R5        8'h00
`define CFG_RST_R6        8'h00
`define CFG_RST_R7        8'h7F
`define CFG_RST_R8        8'h00
`define CFG_RST_R9        8'h00
`define CFG_RST_R10       8'h80

// Write-side clock cycles before a new queue count takes effect
`define CFG_SETTLE_CYCLES 8

// Serial frame: 8 address bits then 8 data bits, first bit is the MSB
`define SER_FRAME_BITS    16

`endif

// ==== rtl/mq_cfg_pkg.sv ====
/*
  Types and shared decode functions of the multi-queue configuration block.
  Assumes mq_cfg_regs.svh is reachable on the include path.
*/
`default_nettype none
`include "mq_cfg_regs.svh"

package mq_cfg_pkg;

  typedef enum logic [1:0] {
    single_queue_mode,
    two_queue_mode,
    four_queue_mode,
    eight_queue_mode
  } queue_mode_t;

  // Main block state
  typedef struct packed {
    logic [`CFG_NUM_REGS-1:0][`CFG_WIDTH-1:0] cfg;
    logic [3:0]                               wptr;
    logic [3:0]                               rptr;
    logic [`CFG_WIDTH-1:0]                    rd_data;
    logic                                     fifo_wr;
    logic                                     fifo_rd;
    logic [2:0]                               wq;
    logic [2:0]                               rq;
    logic                                     wr_bad;
    logic                                     rd_bad;
  } access_state_t;

  // Serial receiver state
  typedef struct packed {
    logic [3:0]            cnt;
    logic [14:0]           shreg;
    logic                  wr;
    logic [3:0]            idx;
    logic [`CFG_WIDTH-1:0] data;
  } serial_state_t;

  // Settling counter state
  typedef struct packed {
    logic [3:0] cnt;
    logic       busy;
    logic [2:0] pending;
    logic [2:0] active;
  } settle_state_t;

  // Queue count field to mode; bit 2 dominates, then bit 1
  function automatic queue_mode_t mode_of(input logic [2:0] field);
    if (field[2])
      mode_of = eight_queue_mode;
    else if (field[1])
      mode_of = four_queue_mode;
    else if (field[0])
      mode_of = two_queue_mode;
    else
      mode_of = single_queue_mode;
  endfunction : mode_of

  // A pick is valid when it names a queue that the mode provides
  function automatic logic pick_ok(input queue_mode_t mode,
                                   input logic [2:0] pick);
    case (mode)
      single_queue_mode: pick_ok = (pick == 3'h0);
      two_queue_mode:    pick_ok = (pick[2:1] == 2'h0);
      four_queue_mode:   pick_ok = !pick[2];
      default:           pick_ok = 1'b1;
    endcase
  endfunction : pick_ok

endpackage : mq_cfg_pkg

`default_nettype wire

// ==== rtl/mq_serial_rx.sv ====
/*
  Serial configuration receiver: shifts one bit per serial clock edge into
  a 16-bit frame (address, then data) and emits a register write.
  Assumes the serial clock arrives as a one-cycle edge pulse on clk_sys.
*/
`default_nettype none
`include "mq_cfg_regs.svh"

module mq_serial_rx
  import mq_cfg_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic                  serial_load_select,
  input  wire logic                  config_load_n,
  input  wire logic                  serial_clk_edge,
  input  wire logic                  serial_data_in,
  output logic                       cfg_wr,
  output logic [3:0]                 cfg_idx,
  output logic [`CFG_WIDTH-1:0]      cfg_data
);

  serial_state_t st;
  serial_state_t next_st;
  logic          frame_on;
  logic [15:0]   word;

  // A frame lives only while serial mode is chosen and load is high
  assign frame_on = !serial_load_select && config_load_n;
  assign word     = {st.shreg, serial_data_in};

  // Bit capture and frame completion
  always_comb
  begin
    next_st    = st;
    next_st.wr = 1'b0;
    if (!frame_on)
      next_st.cnt = 4'h0;
    else if (serial_clk_edge)
    begin
      next_st.shreg = word[14:0]; // RQ13
      if (st.cnt == 4'(`SER_FRAME_BITS - 1))
      begin
        next_st.cnt = 4'h0;
        // Addresses outside the ten registers are dropped silently
        if (word[15:8] >= `CFG_ADDR_FIRST && word[15:8] <= `CFG_ADDR_LAST)
        begin
          next_st.wr   = 1'b1; // RQ14
          next_st.idx  = 4'(word[15:8] - `CFG_ADDR_FIRST);
          next_st.data = word[7:0];
        end
      end
      else
        next_st.cnt = st.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign cfg_wr   = st.wr;
  assign cfg_idx  = st.idx;
  assign cfg_data = st.data;

  AST_SER_FRAME: assert property ( // RQ14
    @(posedge clk_sys) disable iff (sys_rst)
    cfg_wr |-> $past(st.cnt) == 4'hF && $past(frame_on)
      && cfg_idx < 4'(`CFG_NUM_REGS))
    else $error("serial write without a full frame");

endmodule : mq_serial_rx

`default_nettype wire

// ==== rtl/mq_cfg_settle.sv ====
/*
  Holds the queue count in force; a newly written count replaces it only
  after SETTLE write-side clock edges. Assumes write edges are pulses.
*/
`default_nettype none
`include "mq_cfg_regs.svh"

module mq_cfg_settle
  import mq_cfg_pkg::*;
#(
  parameter int SETTLE = `CFG_SETTLE_CYCLES
)
(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       load_start,
  input  wire logic [2:0] load_value,
  input  wire logic       write_tick,
  output logic [2:0]      active_count,
  output logic            settling
);

  settle_state_t st;
  settle_state_t next_st;

  // A fresh write restarts the wait rather than stacking on the old one
  always_comb
  begin
    next_st = st;
    if (load_start)
    begin
      next_st.pending = load_value;
      next_st.busy    = 1'b1;
      next_st.cnt     = 4'h0;
    end
    else if (st.busy && write_tick)
    begin
      if (st.cnt == 4'(SETTLE - 1))
      begin
        next_st.active = st.pending; // RQ16
        next_st.busy   = 1'b0;
      end
      else
        next_st.cnt = st.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      st         <= '0;
      st.active  <= 3'(`CFG_RST_R3);
      st.pending <= 3'(`CFG_RST_R3);
    end
    else
      st <= next_st;
  end

  assign active_count = st.active;
  assign settling     = st.busy;

  AST_SETTLE_LATE: assert property ( // RQ16
    @(posedge clk_sys) disable iff (sys_rst)
    $changed(st.active) |-> $past(st.busy && write_tick
      && st.cnt == 4'(SETTLE - 1)))
    else $error("queue count changed before settling");

endmodule : mq_cfg_settle

`default_nettype wire

// ==== rtl/multiqueue_config_access.sv ====
/*
  Configuration access and queue-select decode of a multi-queue FIFO:
  ten 8-bit configuration registers loaded in parallel or serially, plus
  validation of the read and write queue picks against the queue count.
  Assumes all pins are synchronous to clk_sys and the write, read and
  serial clocks arrive as one-cycle rising-edge pulses.
*/
`default_nettype none
`include "mq_cfg_regs.svh"

// Contract
// (RQ1) Count 000: only pick 000 valid
// (RQ2) Count 001: picks 000 and 001 valid
// (RQ3) Count 01X: picks 000 to 011 valid
// (RQ4) Count 1XX: all eight picks valid
// (RQ5) Parallel write edge loads next register
// (RQ6) Ten registers, write pointer then wraps
// (RQ7) Eleventh write edge rewrites first register
// (RQ8) Parallel read edge shows next register
// (RQ9) Tenth read edge shows tenth register
// (RQ10) Eleventh read edge shows first register
// (RQ11) Load high, write strobe: FIFO write
// (RQ12) Load high, read strobe: FIFO read
// (RQ13) Serial mode captures one bit per edge
// (RQ14) Serial frame addresses any of ten registers
// (RQ15) Controller picks serial or parallel loading
// (RQ16) New count acts after eight write edges
// (RQ17) Controller never reads and writes together
// (RQ18) No serial readback, parallel port only
// (RQ19) Invalid pick: no queue access that cycle
// (RQ20) Serial select and load low: nothing
module multiqueue_config_access
  import mq_cfg_pkg::*;
#(
  parameter int SETTLE = `CFG_SETTLE_CYCLES
)
(
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic                  serial_load_select,
  input  wire logic                  config_load_n,
  input  wire logic                  write_strobe_n,
  input  wire logic                  read_strobe_n,
  input  wire logic                  write_clk_edge,
  input  wire logic                  read_clk_edge,
  input  wire logic                  serial_clk_edge,
  input  wire logic                  serial_data_in,
  input  wire logic [`CFG_WIDTH-1:0] data_in,
  input  wire logic [2:0]            write_queue_pick,
  input  wire logic [2:0]            read_queue_pick,
  output logic [`CFG_WIDTH-1:0]      cfg_read_data,
  output logic                       fifo_write_en,
  output logic [2:0]                 fifo_write_queue,
  output logic                       fifo_read_en,
  output logic [2:0]                 fifo_read_queue,
  output logic                       write_pick_bad,
  output logic                       read_pick_bad,
  output logic [2:0]                 queue_count_active,
  output logic                       config_settling
);

  access_state_t          st;
  access_state_t          next_st;
  logic                   cfg_load;
  logic                   par_wr;
  logic                   par_rd;
  logic                   fifo_wr_req;
  logic                   fifo_rd_req;
  logic                   ser_wr;
  logic [3:0]             ser_idx;
  logic [`CFG_WIDTH-1:0]  ser_data;
  logic                   qc_start;
  logic [2:0]             qc_value;
  queue_mode_t            mode;
  logic                   w_ok;
  logic                   r_ok;
  logic [`CFG_WIDTH-1:0]  rd_word;

  // Serial frames only form while serial mode and load high
  mq_serial_rx u_serial
  (
    .clk_sys            (clk_sys),
    .sys_rst            (sys_rst),
    .serial_load_select (serial_load_select),
    .config_load_n      (config_load_n),
    .serial_clk_edge    (serial_clk_edge),
    .serial_data_in     (serial_data_in),
    .cfg_wr             (ser_wr),
    .cfg_idx            (ser_idx),
    .cfg_data           (ser_data)
  );

  // Queue count in force lags the register by the settling time
  mq_cfg_settle #(
    .SETTLE (SETTLE)
  ) u_settle
  (
    .clk_sys      (clk_sys),
    .sys_rst      (sys_rst),
    .load_start   (qc_start),
    .load_value   (qc_value),
    .write_tick   (write_clk_edge),
    .active_count (queue_count_active),
    .settling     (config_settling)
  );

  // Access decode; the strobes must oppose so that no cycle both reads
  // and writes the register file
  assign cfg_load    = serial_load_select && !config_load_n; // RQ20
  assign par_wr      = cfg_load && !write_strobe_n && read_strobe_n
                       && write_clk_edge;  // RQ5
  assign par_rd      = cfg_load && !read_strobe_n && write_strobe_n
                       && read_clk_edge;   // RQ8
  assign fifo_wr_req = config_load_n && !write_strobe_n
                       && write_clk_edge;  // RQ11
  assign fifo_rd_req = config_load_n && !read_strobe_n
                       && read_clk_edge;   // RQ12

  // Queue count register written by either path restarts the settling
  assign qc_start = (par_wr && st.wptr == `CFG_QCOUNT_IDX)
                    || (ser_wr && ser_idx == `CFG_QCOUNT_IDX); // RQ16
  // The value follows whichever path actually hit the queue-count register
  assign qc_value = (par_wr && st.wptr == `CFG_QCOUNT_IDX)
                    ? data_in[`CFG_QCOUNT_MSB:`CFG_QCOUNT_LSB]
                    : ser_data[`CFG_QCOUNT_MSB:`CFG_QCOUNT_LSB];

  // Picks are judged against the count in force, not the raw register
  assign mode    = mode_of(queue_count_active);
  assign w_ok    = pick_ok(mode, write_queue_pick); // RQ1 RQ2 RQ3 RQ4
  assign r_ok    = pick_ok(mode, read_queue_pick);  // RQ1 RQ2 RQ3 RQ4
  assign rd_word = st.cfg[st.rptr];

  // Next-state logic of the register file, pointers and FIFO strobes
  always_comb
  begin
    next_st        = st;
    next_st.fifo_wr = 1'b0;
    next_st.fifo_rd = 1'b0;
    next_st.wr_bad  = 1'b0;
    next_st.rd_bad  = 1'b0;
    // Outside parallel load the sequences restart at the first register;
    // this also covers the illegal serial-select-low, load-low case
    if (!cfg_load)
    begin
      next_st.wptr = 4'h0;
      next_st.rptr = 4'h0;
    end
    // A serial write lands one cycle after its frame, so it can meet a
    // parallel write; the parallel one is applied last and wins
    if (ser_wr)
      next_st.cfg[ser_idx] = ser_data; // RQ14
    if (par_wr)
    begin
      next_st.cfg[st.wptr] = data_in; // RQ5
      if (st.wptr == 4'(`CFG_NUM_REGS - 1))
        next_st.wptr = 4'h0; // RQ6 RQ7
      else
        next_st.wptr = st.wptr + 4'h1;
    end
    if (par_rd)
    begin
      // Readback only through this port, whichever path loaded it
      next_st.rd_data = rd_word; // RQ8 RQ18
      if (st.rptr == 4'(`CFG_NUM_REGS - 1))
        next_st.rptr = 4'h0; // RQ9 RQ10
      else
        next_st.rptr = st.rptr + 4'h1;
    end
    // A bad pick is flagged, not dropped silently, so the datapath can see it
    if (fifo_wr_req)
    begin
      if (w_ok)
      begin
        next_st.fifo_wr = 1'b1; // RQ11
        next_st.wq      = write_queue_pick;
      end
      else
        next_st.wr_bad = 1'b1; // RQ19
    end
    if (fifo_rd_req)
    begin
      if (r_ok)
      begin
        next_st.fifo_rd = 1'b1; // RQ12
        next_st.rq      = read_queue_pick;
      end
      else
        next_st.rd_bad = 1'b1; // RQ19
    end
  end

  // State register with the register reset values
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      st        <= '0;
      st.cfg[0] <= `CFG_RST_R1;
      st.cfg[1] <= `CFG_RST_R2;
      st.cfg[2] <= `CFG_RST_R3;
      st.cfg[3] <= `CFG_RST_R4;
      st.cfg[4] <= `CFG_RST_R5;
      st.cfg[5] <= `CFG_RST_R6;
      st.cfg[6] <= `CFG_RST_R7;
      st.cfg[7] <= `CFG_RST_R8;
      st.cfg[8] <= `CFG_RST_R9;
      st.cfg[9] <= `CFG_RST_R10;
    end
    else
      st <= next_st;
  end

  // Outputs come straight from the state flops
  assign cfg_read_data    = st.rd_data;
  assign fifo_write_en    = st.fifo_wr;
  assign fifo_write_queue = st.wq;
  assign fifo_read_en     = st.fifo_rd;
  assign fifo_read_queue  = st.rq;
  assign write_pick_bad   = st.wr_bad;
  assign read_pick_bad    = st.rd_bad;

  // Checks on the access sequences; they watch the decoded requests, so
  // they also hold when a controller drives the strobes out of order
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence s_par_write;
    serial_load_select && !config_load_n && !write_strobe_n
      && read_strobe_n && write_clk_edge;
  endsequence

  sequence s_par_read;
    serial_load_select && !config_load_n && !read_strobe_n
      && write_strobe_n && read_clk_edge;
  endsequence

  sequence s_illegal;
    !serial_load_select && !config_load_n;
  endsequence

  AST_PAR_WRITE: assert property ( // RQ5
    s_par_write |=> st.cfg[$past(st.wptr)] == $past(data_in))
    else $error("parallel write did not load the pointed register");

  AST_WPTR_WRAP: assert property ( // RQ6 RQ7
    s_par_write ##0 (st.wptr == 4'h9) |=> st.wptr == 4'h0)
    else $error("write pointer did not wrap after tenth register");

  AST_WPTR_STEP: assert property ( // RQ5
    s_par_write ##0 (st.wptr != 4'h9) |=> st.wptr == $past(st.wptr) + 4'h1)
    else $error("write pointer did not step to the next register");

  AST_PAR_READ: assert property ( // RQ8
    s_par_read |=> cfg_read_data == $past(rd_word))
    else $error("parallel read returned wrong register");

  AST_RPTR_WRAP: assert property ( // RQ9 RQ10
    s_par_read ##0 (st.rptr == 4'h9) |=> st.rptr == 4'h0
      ##0 cfg_read_data == $past(st.cfg[9]))
    else $error("read pointer did not wrap after tenth register");

  AST_FIFO_WRITE: assert property ( // RQ11
    fifo_wr_req && w_ok |=> fifo_write_en
      && fifo_write_queue == $past(write_queue_pick))
    else $error("valid FIFO write was not issued");

  AST_FIFO_READ: assert property ( // RQ12
    fifo_rd_req && r_ok |=> fifo_read_en
      && fifo_read_queue == $past(read_queue_pick))
    else $error("valid FIFO read was not issued");

  AST_BAD_PICK: assert property ( // RQ19
    fifo_wr_req && !w_ok |=> write_pick_bad && !fifo_write_en)
    else $error("invalid write queue pick was acted on");

  AST_BAD_READ_PICK: assert property ( // RQ19
    fifo_rd_req && !r_ok |=> read_pick_bad && !fifo_read_en)
    else $error("invalid read queue pick was acted on");

  AST_QUEUE_RANGE: assert property ( // RQ1 RQ2 RQ3 RQ4
    fifo_write_en |-> pick_ok(mode_of($past(queue_count_active)),
                              fifo_write_queue))
    else $error("FIFO write to a queue outside the count");

  AST_READ_RANGE: assert property ( // RQ1 RQ2 RQ3 RQ4
    fifo_read_en |-> pick_ok(mode_of($past(queue_count_active)),
                             fifo_read_queue))
    else $error("FIFO read from a queue outside the count");

  // Only a parallel read moves the output port: no serial readback path
  AST_READBACK_ONLY: assert property ( // RQ18
    $changed(cfg_read_data) && !$past(sys_rst) |-> $past(par_rd))
    else $error("read data changed without a parallel read");

  // The old count stays in force for the whole settling wait
  AST_COUNT_HELD: assert property ( // RQ16
    config_settling |-> $stable(queue_count_active))
    else $error("queue count moved while a new one was settling");

  AST_ILLEGAL_PTR: assert property ( // RQ20
    s_illegal |=> st.wptr == 4'h0 && st.rptr == 4'h0)
    else $error("illegal mode left a register pointer advanced");

  AST_ILLEGAL: assert property ( // RQ20
    s_illegal |=> $stable(st.cfg) && !fifo_write_en && !fifo_read_en)
    else $error("illegal mode changed registers or FIFO");

endmodule : multiqueue_config_access

`default_nettype wire

// ==== verification/host_ctl_model.sv ====
/*
  Host controller model: drives every control, strobe and programming pin
  of the configuration block. Assumes its tasks are started at a falling
  clock edge and each one but set_idle returns at a later falling edge.
*/
`default_nettype none

module host_ctl_model
(
  input  wire logic       clk_sys,
  output logic            serial_load_select,
  output logic            config_load_n,
  output logic            write_strobe_n,
  output logic            read_strobe_n,
  output logic            write_clk_edge,
  output logic            read_clk_edge,
  output logic            serial_clk_edge,
  output logic            serial_data_in,
  output logic [7:0]      data_in,
  output logic [2:0]      write_queue_pick,
  output logic [2:0]      read_queue_pick
);
  timeunit 1ns;
  timeprecision 1ps;

  // Parallel select, no access; serial clock still, data line wanders
  task automatic set_idle;
    serial_load_select = 1'b1;
    config_load_n = 1'b1;
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    write_clk_edge = 1'b0;
    read_clk_edge = 1'b0;
    serial_clk_edge = 1'b0;
    serial_data_in = !serial_data_in;
  endtask : set_idle

  task automatic idle;
    set_idle();
    @(negedge clk_sys);
  endtask : idle

  // Pins defined from time zero
  initial
  begin
    serial_data_in = 1'b0;
    data_in = 8'h00;
    write_queue_pick = 3'h0;
    read_queue_pick = 3'h0;
    set_idle();
  end

  // One parallel register access; the strobes are never low together
  task automatic par(input logic wr, input logic [7:0] d);
    serial_load_select = 1'b1;
    config_load_n = 1'b0;
    write_strobe_n = !wr;
    read_strobe_n = wr;
    write_clk_edge = wr;
    read_clk_edge = !wr;
    data_in = d;
    @(negedge clk_sys);
  endtask : par

  // One queue access with load high; loading method is free here
  task automatic fifo(input logic wr, input logic [2:0] p, input logic sel);
    serial_load_select = sel;
    config_load_n = 1'b1;
    write_strobe_n = !wr;
    read_strobe_n = wr;
    write_clk_edge = wr;
    read_clk_edge = !wr;
    write_queue_pick = p;
    read_queue_pick = p;
    @(negedge clk_sys);
  endtask : fifo

  // Serial frame, address then data, first bit the MSB, slow clock
  task automatic frame(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] bits;
    bits = {a, d};
    serial_load_select = 1'b0;
    config_load_n = 1'b1;
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    write_clk_edge = 1'b0;
    read_clk_edge = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      serial_data_in = bits[i];
      serial_clk_edge = 1'b1;
      @(negedge clk_sys);
      serial_clk_edge = 1'b0;
      @(negedge clk_sys);
    end
    // Stay in serial mode so the last write is not cut short
    repeat (3) @(negedge clk_sys);
  endtask : frame

  // Serial select and load both low with a write edge
  task automatic illegal;
    serial_load_select = 1'b0;
    config_load_n = 1'b0;
    write_strobe_n = 1'b0;
    read_strobe_n = 1'b1;
    write_clk_edge = 1'b1;
    read_clk_edge = 1'b0;
    @(negedge clk_sys);
  endtask : illegal

endmodule : host_ctl_model

`default_nettype wire

// ==== verification/testbench.sv ====
/*
  Self-checking bench: a reference model with integer pointers and a
  register array is compared with the block at every answer.
  Assumes the host model drives all inputs but clk_sys and sys_rst; a new count settles after the
  full count of write edges from the register header.
*/
`default_nettype none
`include "mq_cfg_regs.svh"

module testbench
  import mq_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SETTLE = `CFG_SETTLE_CYCLES;

  logic       clk_sys = 1'b0;
  logic       sys_rst = 1'b1;
  logic       serial_load_select;
  logic       config_load_n;
  logic       write_strobe_n;
  logic       read_strobe_n;
  logic       write_clk_edge;
  logic       read_clk_edge;
  logic       serial_clk_edge;
  logic       serial_data_in;
  logic [7:0] data_in;
  logic [2:0] write_queue_pick;
  logic [2:0] read_queue_pick;
  logic [7:0] cfg_read_data;
  logic       fifo_write_en;
  logic [2:0] fifo_write_queue;
  logic       fifo_read_en;
  logic [2:0] fifo_read_queue;
  logic       write_pick_bad;
  logic       read_pick_bad;
  logic [2:0] queue_count_active;
  logic       config_settling;
  int         err_total = 0;
  int         compares = 0;
  int         seed = 15;
  int         wp = 0;
  int         rp = 0;
  int         act = 7;
  int         last_wq = 0;
  int         last_rq = 0;
  logic [7:0] regs [10] = '{`CFG_RST_R1, `CFG_RST_R2, `CFG_RST_R3,
    `CFG_RST_R4, `CFG_RST_R5, `CFG_RST_R6, `CFG_RST_R7, `CFG_RST_R8,
    `CFG_RST_R9, `CFG_RST_R10};

  // System clock, 8 ns period
  always #4 clk_sys = !clk_sys;

  multiqueue_config_access #(.SETTLE(SETTLE)) multiqueue_config_access_i (
    .clk_sys, .sys_rst, .serial_load_select, .config_load_n,
    .write_strobe_n, .read_strobe_n, .write_clk_edge, .read_clk_edge,
    .serial_clk_edge, .serial_data_in, .data_in, .write_queue_pick,
    .read_queue_pick, .cfg_read_data, .fifo_write_en, .fifo_write_queue,
    .fifo_read_en, .fifo_read_queue, .write_pick_bad, .read_pick_bad,
    .queue_count_active, .config_settling
  );

  host_ctl_model host_ctl_model_i (
    .clk_sys, .serial_load_select, .config_load_n, .write_strobe_n,
    .read_strobe_n, .write_clk_edge, .read_clk_edge, .serial_clk_edge,
    .serial_data_in, .data_in, .write_queue_pick, .read_queue_pick
  );

  task automatic close_out;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  // One comparison; X in the seen value never matches
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // Leaving config access sends both pointers back to the first register
  task automatic idle;
    host_ctl_model_i.idle();
    wp = 0;
    rp = 0;
  endtask : idle

  task automatic wr_cfg(input logic [7:0] d);
    host_ctl_model_i.par(1'b1, d);
    regs[wp] = d;
    wp = (wp + 1) % 10;
  endtask : wr_cfg

  task automatic rd_cfg;
    host_ctl_model_i.par(1'b0, 8'h00);
    chk("cfg_read_data", regs[rp], cfg_read_data);
    rp = (rp + 1) % 10;
  endtask : rd_cfg

  // Queue access; validity of the pick follows the count in force
  task automatic fifo(input logic wr, input int p);
    logic ok;
    ok = (act >= 4) || (act >= 2 && p < 4) || (act == 1 && p < 2) || p == 0;
    host_ctl_model_i.fifo(wr, p[2:0], 1'($random(seed)));
    if (ok && wr)
      last_wq = p;
    if (ok && !wr)
      last_rq = p;
    chk("queue_en", 8'(ok),
        8'(wr ? fifo_write_en : fifo_read_en));
    chk("pick_bad", 8'(!ok),
        8'(wr ? write_pick_bad : read_pick_bad));
    chk("queue", 8'(wr ? last_wq : last_rq),
        8'(wr ? fifo_write_queue : fifo_read_queue));
  endtask : fifo

  // Watchdog: a hung run ends as a failure
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    close_out();
  end

  // Main sequence
  initial
  begin
    logic [7:0] d;
    repeat (8) @(negedge clk_sys);
    sys_rst = 1'b0;
    chk("queue_count_active", 8'h07, 8'(queue_count_active));
    repeat (11) rd_cfg();
    idle();
    $display("test reset_readback done");
    repeat (11) wr_cfg(8'($random(seed)));
    idle();
    act = regs[2][2:0];
    chk("queue_count_active", 8'(act), 8'(queue_count_active));
    chk("config_settling", 8'h00, 8'(config_settling));
    repeat (11) rd_cfg();
    idle();
    $display("test parallel_wrap done");
    for (int m = 0; m < 8; m++)
    begin
      d = {5'($random(seed)), 3'(m)};
      host_ctl_model_i.frame(8'h03, d);
      regs[2] = d;
      host_ctl_model_i.frame(8'h0B, 8'($random(seed)));
      wr_cfg(8'($random(seed)));
      wr_cfg(8'($random(seed)));
      idle();
      // Pick 0 is valid in every mode, so these writes only count edges
      repeat (SETTLE - 3) fifo(1'b1, 0);
      chk("queue_count_active", 8'(act), 8'(queue_count_active));
      chk("config_settling", 8'h01, 8'(config_settling));
      fifo(1'b1, 0);
      act = m;
      chk("queue_count_active", 8'(act), 8'(queue_count_active));
      chk("config_settling", 8'h00, 8'(config_settling));
      for (int p = 0; p < 8; p++)
      begin
        fifo(1'b1, p);
        fifo(1'b0, p);
      end
      idle();
    end
    $display("test queue_modes done");
    host_ctl_model_i.illegal();
    chk("fifo_write_en", 8'h00, 8'(fifo_write_en));
    idle();
    repeat (10) rd_cfg();
    idle();
    $display("test illegal_and_readback done");
    close_out();
  end

endmodule : testbench

`default_nettype wire
